// file: arc_corr_dp.sv
// Gain and offset correction datapath with saturation
`timescale 1ns/1ns
`include "arc_regs.svh"
module arc_corr_dp (
    input  wire logic   i_clock,
    input  wire logic   i_rst_n,
    arc_corr_if.dp      bus
);
    import arc_pkg::*;

    arc_state_e   state_q, state_d;
    logic [23:0]  prod_q;
    logic [11:0]  res_q;
    logic         done_q;

    // Clamp a signed sum into the unsigned result range
    function automatic logic [11:0] sat12(input logic signed [14:0] v);
        if (v < 0)
            sat12 = 12'h000;
        else if (v > $signed({3'h0, `ARC_RES_MAX}))
            sat12 = `ARC_RES_MAX;
        else
            sat12 = v[11:0];
    endfunction

    // Raw times Q1.11 gain; rounding by half an lsb
    wire logic [23:0] prod_w = bus.raw * bus.gain;
    wire logic [13:0] scaled_w = 14'(({1'b0, prod_q} + 25'h400) >> 11);
    wire logic signed [14:0] sum_w =
        $signed({1'b0, scaled_w}) + 15'($signed(bus.offset));
    wire logic signed [14:0] clip_w =
        (scaled_w > 14'h1FFF) ? 15'h1FFF : sum_w;

    // Two-stage sequencer; product registered to keep timing short
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ARC_IDLE: if (bus.start) begin
                state_d = ARC_MULT;
            end
            ARC_MULT: state_d = ARC_DONE;
            ARC_DONE: state_d = ARC_IDLE;
            default:  state_d = ARC_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q <= ARC_IDLE;
            prod_q  <= 24'h000000;
            res_q   <= 12'h000;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            done_q  <= (state_q == ARC_MULT);
            if (state_q == ARC_IDLE && bus.start)
                prod_q <= prod_w;
            if (state_q == ARC_MULT)
                res_q <= sat12(clip_w);
        end
    end

    assign bus.done   = done_q;
    assign bus.result = res_q;
endmodule

// file: arc_corr_if.sv
// Carrier between the register top and the correction datapath
`timescale 1ns/1ns
interface arc_corr_if;
    import arc_pkg::*;
    logic        start;
    arc_sample_t raw;
    arc_sample_t gain;
    arc_sample_t offset;
    logic        done;
    arc_sample_t result;
    modport ctrl (output start, raw, gain, offset, input done, result);
    modport dp   (input start, raw, gain, offset, output done, result);
endinterface

// file: arc_pkg.sv
// Types shared by the ADC correction tail modules
package arc_pkg;
    typedef logic [11:0] arc_sample_t;
    typedef logic [7:0]  arc_addr_t;
    typedef logic [15:0] arc_data_t;
    typedef enum logic [1:0] {
        ARC_IDLE = 2'b00,
        ARC_MULT = 2'b01,
        ARC_DONE = 2'b10
    } arc_state_e;
endpackage

// file: arc_regs.svh
// Register offsets, field positions and reset values for the ADC correction tail
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ARC_GAIN_OFS      8'h24
`define ARC_OFFSET_OFS    8'h26
`define ARC_TRIM_OFS      8'h28
`define ARC_DEBUG_OFS     8'h2A
`define ARC_CTRL_OFS      8'h2C
`define ARC_STATUS_OFS    8'h2E
`define ARC_GAIN_RST      12'h000
`define ARC_OFFSET_RST    12'h000
`define ARC_TRIM_RST      11'h000
`define ARC_DEBUG_RST     1'b0
`define ARC_CTRL_CORR_BIT 0
`define ARC_CTRL_EN_BIT   1
`define ARC_RES_MAX       12'hFFF
`define ARC_CORR_LAT      2
`endif

// file: arc_top.sv
// ADC result correction, trim storage and debug-run control
// Register words are 16 bits on even byte offsets; only the implemented
// low bits are stored, everything above reads back as zero:
//   0x24 gain_correction    bits 11:0, unsigned Q1.11
//   0x26 offset_correction  bits 11:0, two's complement
//   0x28 factory_trim       bits 10:8 bias, bits 7:0 linearity
//   0x2A debug_behaviour    bit 0 debug_run
//   0x2C control            bit 0 correction_enable, bit 1 enable
//   0x2E status             bit 0 run, bit 1 busy, read only
// Other offsets read zero and ignore writes.
//
// Read data stand for exactly one cycle after the read strobe and are
// zero otherwise, so a master must take them in that cycle.
//
// A corrected sample holds o_busy high for three cycles; its result and
// the o_result_valid pulse follow on the next cycle. With correction off
// the sample passes through one cycle after it is taken. Samples offered
// while the converter is halted or a correction runs are dropped, so the
// engine upstream must not offer them faster than one per four cycles.
//
// The debug pin is asynchronous and passes two flops, so the run
// permission follows it three cycles late. The trim fields are not
// checked here: whatever software writes goes straight to the analog side.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "arc_regs.svh"
module arc_top (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    input  wire arc_pkg::arc_addr_t   i_addr,
    input  wire arc_pkg::arc_data_t   i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic [15:0]               o_rdata,
    input  wire logic                 i_conv_valid,
    input  wire arc_pkg::arc_sample_t i_conv_data,
    input  wire logic                 i_cpu_debug,
    output logic                      o_result_valid,
    output logic [11:0]               o_result,
    output logic                      o_conv_run,
    output logic                      o_busy,
    output logic [2:0]                o_bias_trim,
    output logic [7:0]                o_linearity_trim
);
    import arc_pkg::*;

    // Carrier to the correction datapath
    arc_corr_if cif ();

    // Software-visible register state
    logic [11:0] gain_q;
    logic [11:0] offset_q;
    logic [10:0] trim_q;
    logic        dbg_run_q;
    logic        corr_en_q;
    logic        enable_q;
    logic [15:0] rdata_q;

    // Debug pin synchroniser and run permission
    logic        dbg_s1_q;
    logic        dbg_s2_q;
    logic        run_q;

    // Sample capture and datapath handshake
    logic        pend_q;
    logic [11:0] raw_q;
    logic        start_q;

    // Result outputs
    logic        rvalid_q;
    logic [11:0] result_q;

    // Register select; one compare shared by the write and read paths
    function automatic logic addr_hit(input arc_addr_t addr,
                                      input arc_addr_t ofs);
        addr_hit = (addr == ofs);
    endfunction

    // Zero-extend a 12-bit field into a bus word
    function automatic arc_data_t rd_word(input logic [11:0] field);
        rd_word = {4'h0, field};
    endfunction

    // One select line per mapped register
    wire logic sel_gain   = addr_hit(i_addr, `ARC_GAIN_OFS);
    wire logic sel_offset = addr_hit(i_addr, `ARC_OFFSET_OFS);
    wire logic sel_trim   = addr_hit(i_addr, `ARC_TRIM_OFS);
    wire logic sel_debug  = addr_hit(i_addr, `ARC_DEBUG_OFS);
    wire logic sel_ctrl   = addr_hit(i_addr, `ARC_CTRL_OFS);
    wire logic sel_status = addr_hit(i_addr, `ARC_STATUS_OFS);

    // Write strobes; an unmapped address selects nothing and is dropped
    wire logic wr_gain   = i_wr && sel_gain;
    wire logic wr_offset = i_wr && sel_offset;
    wire logic wr_trim   = i_wr && sel_trim;
    wire logic wr_debug  = i_wr && sel_debug;
    wire logic wr_ctrl   = i_wr && sel_ctrl;

    // Write data cut to the stored field widths; reserved bits fall away
    wire logic [11:0] gain_wd   = i_wdata[11:0];
    wire logic [11:0] offset_wd = i_wdata[11:0];
    wire logic [10:0] trim_wd   = i_wdata[10:0];
    wire logic        dbg_wd    = i_wdata[0];
    wire logic        corr_wd   = i_wdata[`ARC_CTRL_CORR_BIT];
    wire logic        en_wd     = i_wdata[`ARC_CTRL_EN_BIT];

    // Debug-run only takes while converter is off
    wire logic dbg_take = wr_debug && !enable_q;

    // Converter halts in debug unless debug-run is set
    wire logic run_d = enable_q && (dbg_run_q || !dbg_s2_q);

    // Accept a conversion only while running and datapath idle
    wire logic take_conv = i_conv_valid && run_q && !pend_q;
    // Taken samples either launch a correction or pass straight through
    wire logic launch    = take_conv && corr_en_q;
    wire logic bypass    = take_conv && !corr_en_q;

    // Read words; reserved bits tied to zero
    wire logic [15:0] gain_rw   = rd_word(gain_q);
    wire logic [15:0] offset_rw = rd_word(offset_q);
    wire logic [15:0] trim_rw   = {5'h00, trim_q};
    wire logic [15:0] debug_rw  = {15'h0000, dbg_run_q};
    wire logic [15:0] ctrl_rw   = {14'h0000, enable_q, corr_en_q};
    wire logic [15:0] status_rw = {14'h0000, pend_q, run_q};

    // Read mux; unmapped addresses read zero
    wire logic [15:0] rd_mux =
        sel_gain   ? gain_rw :
        sel_offset ? offset_rw :
        sel_trim   ? trim_rw :
        sel_debug  ? debug_rw :
        sel_ctrl   ? ctrl_rw :
        sel_status ? status_rw :
        16'h0000;

    // Gain field; software may retune it at any time
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            gain_q <= `ARC_GAIN_RST;
        end else if (wr_gain) begin
            gain_q <= gain_wd;
        end
    end

    // Offset field, kept as written; sign is handled in the datapath
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            offset_q <= `ARC_OFFSET_RST;
        end else if (wr_offset) begin
            offset_q <= offset_wd;
        end
    end

    // Trim copy; stored as written, the value is not checked
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            trim_q <= `ARC_TRIM_RST;
        end else if (wr_trim) begin
            trim_q <= trim_wd;
        end
    end

    // Debug-run bit; a write while enabled is silently lost
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            dbg_run_q <= `ARC_DEBUG_RST;
        end else if (dbg_take) begin
            dbg_run_q <= dbg_wd;
        end
    end

    // Control bits: correction enable and converter enable
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            corr_en_q <= 1'b0;
            enable_q  <= 1'b0;
        end else if (wr_ctrl) begin
            corr_en_q <= corr_wd;
            enable_q  <= en_wd;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // Debug request comes from another domain: two flops
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
        end else begin
            dbg_s1_q <= i_cpu_debug;
            dbg_s2_q <= dbg_s1_q;
        end
    end

    // Run permission, registered so o_conv_run leaves a flop
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // Correction launch pulse towards the datapath
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= launch;
        end
    end

    // Raw sample latch; held for the datapath's whole run
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            raw_q <= 12'h000;
        end else if (take_conv) begin
            raw_q <= i_conv_data;
        end
    end

    // Busy from launch until done; a launch never meets a done
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
        end else if (launch) begin
            pend_q <= 1'b1;
        end else if (cif.done) begin
            pend_q <= 1'b0;
        end
    end

    assign cif.start  = start_q;
    assign cif.raw    = raw_q;
    assign cif.gain   = gain_q;
    assign cif.offset = offset_q;

    // Correction datapath; three cycles from launch to done
    arc_corr_dp u_dp (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .bus     (cif.dp)
    );

    // Result pulse: one cycle per finished or bypassed sample
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cif.done || bypass;
        end
    end

    // Result word: corrected value or the raw sample, then held
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            result_q <= 12'h000;
        end else if (cif.done) begin
            result_q <= cif.result;
        end else if (bypass) begin
            result_q <= i_conv_data;
        end
    end

    // Ports driven straight from the flops above
    assign o_rdata          = rdata_q;
    assign o_result_valid   = rvalid_q;
    assign o_result         = result_q;
    assign o_conv_run       = run_q;
    assign o_busy           = pend_q;
    assign o_bias_trim      = trim_q[10:8];
    assign o_linearity_trim = trim_q[7:0];
endmodule

// file: arc_top_properties.sv
// Port-level properties of the ADC correction tail
`timescale 1ns/1ns
module arc_top_properties (
    input wire logic                 i_clock,
    input wire logic                 i_rst_n,
    input wire arc_pkg::arc_addr_t   i_addr,
    input wire arc_pkg::arc_data_t   i_wdata,
    input wire logic                 i_wr,
    input wire logic                 i_rd,
    input wire logic [15:0]          o_rdata,
    input wire logic                 i_conv_valid,
    input wire arc_pkg::arc_sample_t i_conv_data,
    input wire logic                 i_cpu_debug,
    input wire logic                 o_result_valid,
    input wire logic [11:0]          o_result,
    input wire logic                 o_conv_run,
    input wire logic                 o_busy,
    input wire logic [2:0]           o_bias_trim,
    input wire logic [7:0]           o_linearity_trim
);
    import arc_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Corrected path: three busy cycles, then the result pulse
    a_corr_latency: assert property ($rose(o_busy) |->
        o_busy [*3] ##1 (o_result_valid && !o_busy))
        else $error("corrected result timing wrong");
    // A result needs an accepted sample or a finishing correction
    a_valid_cause: assert property (o_result_valid |->
        $past(o_busy) || $past(i_conv_valid && o_conv_run))
        else $error("result pulse without cause");
    a_result_holds: assert property (!o_result_valid |->
        $stable(o_result)) else $error("result moved without pulse");
    // Halted converter drops samples
    a_halt_refuses: assert property ((i_conv_valid && !o_conv_run
        && !o_busy) |=> !o_busy && !o_result_valid)
        else $error("sample taken while halted");
    a_trim_follows: assert property ((i_wr && i_addr == 8'h28) |=>
        {5'h00, o_bias_trim, o_linearity_trim} == ($past(i_wdata)
        & 16'h07FF)) else $error("trim outputs not the written copy");
    // Reserved bits read as zero
    a_corr_resv_zero: assert property ((i_rd && i_addr inside
        {8'h24, 8'h26}) |=> o_rdata[15:12] == 4'h0)
        else $error("correction reserved bits set");
    a_trim_resv_zero: assert property ((i_rd && i_addr == 8'h28) |=>
        o_rdata[15:11] == 5'h00) else $error("trim reserved bits set");
    a_dbg_resv_zero: assert property ((i_rd && i_addr == 8'h2A) |=>
        o_rdata[15:1] == 15'h0000) else $error("debug reserved bits set");
    c_corrected: cover property ($rose(o_busy));
    c_result: cover property (o_result_valid);
    c_halted: cover property (i_conv_valid && !o_conv_run);
endmodule

bind arc_top arc_top_properties arc_top_properties_inst (.*);

// file: arc_top_tb_top.sv
// Self-checking bench for the ADC correction tail
`timescale 1ns/1ns
module arc_top_tb_top;
    import arc_pkg::*;
    logic        i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
    logic        i_conv_valid = 0, i_cpu_debug = 0;
    arc_addr_t   i_addr = 8'h00;
    arc_data_t   i_wdata = 16'h0000;
    arc_sample_t i_conv_data = 12'h000;
    logic [15:0] o_rdata;
    logic        o_result_valid, o_conv_run, o_busy;
    logic [11:0] o_result;
    logic [2:0]  o_bias_trim;
    logic [7:0]  o_linearity_trim;
    int          mismatches = 0, checks_done = 0;
    always #4 i_clock = ~i_clock;
    arc_top arc_top_inst (.*);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus cycles: one-cycle strobes, read data in the following cycle
    task automatic wr(input arc_addr_t a, input arc_data_t d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input arc_addr_t a, input arc_data_t exp);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    // One sample in; bounded wait keeps a lost result from hanging
    task automatic conv(input arc_sample_t raw, input logic [11:0] exp);
        int n = 0;
        @(posedge i_clock);
        i_conv_valid <= 1'b1;
        i_conv_data <= raw;
        @(posedge i_clock);
        i_conv_valid <= 1'b0;
        #1;
        while (o_result_valid !== 1'b1 && n < 8) begin
            @(posedge i_clock);
            #1 n++;
        end
        if (n == 8) begin
            mismatches++;
            end_sim();
        end else begin
            chk({4'h0, o_result}, {4'h0, exp});
        end
    endtask
    task automatic t_fields;
        arc_addr_t a[4] = '{8'h24, 8'h26, 8'h28, 8'h2A};
        arc_data_t m[4] = '{16'h0FFF, 16'h0FFF, 16'h07FF, 16'h0001};
        foreach (a[i]) begin
            rchk(a[i], 16'h0000);
            wr(a[i], 16'hFFFF);
            rchk(a[i], m[i]);
        end
        chk({5'h00, o_bias_trim, o_linearity_trim}, 16'h07FF);
        rchk(8'h30, 16'h0000);
        wr(8'h2A, 16'h0000);
    endtask
    // Gain, signed offset and both clamp limits
    task automatic t_corr;
        arc_sample_t g[5] = '{12'h800, 12'hC00, 12'h800, 12'h800, 12'hFFF};
        arc_sample_t o[5] = '{12'h005, 12'h000, 12'hFFD, 12'hFFB, 12'h000};
        arc_sample_t r[5] = '{12'h064, 12'h100, 12'h00A, 12'h002, 12'hFFF};
        arc_sample_t e[5] = '{12'h069, 12'h180, 12'h007, 12'h000, 12'hFFF};
        wr(8'h2C, 16'h0003);
        repeat (4) @(posedge i_clock);
        foreach (g[i]) begin
            wr(8'h24, {4'h0, g[i]});
            wr(8'h26, {4'h0, o[i]});
            conv(r[i], e[i]);
        end
        wr(8'h2C, 16'h0002);
        conv(12'h123, 12'h123);
    endtask
    task automatic t_debug;
        wr(8'h2A, 16'h0001);
        rchk(8'h2A, 16'h0000);
        @(posedge i_clock);
        i_cpu_debug <= 1'b1;
        repeat (5) @(posedge i_clock);
        #1 chk({15'h0, o_conv_run}, 16'h0000);
        @(posedge i_clock);
        i_conv_valid <= 1'b1;
        i_conv_data <= 12'h3AB;
        @(posedge i_clock);
        i_conv_valid <= 1'b0;
        repeat (5) @(posedge i_clock);
        #1 chk({4'h0, o_result}, 16'h0123);
        wr(8'h2C, 16'h0000);
        wr(8'h2A, 16'h0001);
        rchk(8'h2A, 16'h0001);
        wr(8'h2C, 16'h0002);
        repeat (5) @(posedge i_clock);
        #1 chk({15'h0, o_conv_run}, 16'h0001);
        conv(12'h055, 12'h055);
        rchk(8'h2C, 16'h0002);
        rchk(8'h2E, 16'h0001);
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_fields();
        t_corr();
        t_debug();
        end_sim();
    end
endmodule
